// File: pkg/vicp_pkg.sv
package vicp_pkg;

    // ==========================================================
    // register map
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] INPUT_OFS = 4'h4;
    localparam logic [3:0] DIV_OFS = 4'h8;

    // ==========================================================
    // field layout
    localparam int RUN_BIT = 0;
    localparam int PREC_LSB = 1;
    localparam int PREC_MSB = 3;
    localparam int CODE_W = 16;

    // ==========================================================
    // reset values
    localparam logic [2:0] PREC_RST = 3'h0;
    localparam logic [15:0] CODE_RST = 16'h0000;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [15:0] DIV_ZERO = 16'h0000;

    // ==========================================================
    // modulator states
    typedef enum logic [0:0] {
        VICP_IDLE = 1'b0,
        VICP_RUN = 1'b1
    } vicp_state_type;

endpackage

// File: src/vicp_top.sv
module vicp_top
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator control
    output logic vcxo_ctrl_out
);

    // ==========================================================
    // register state
    logic run_r, run_nxt;
    logic [2:0] prec_r, prec_nxt;
    logic [15:0] code_r, code_nxt;
    logic [15:0] div_r, div_nxt;
    logic [31:0] prdata_r, prdata_nxt;

    // ==========================================================
    // modulator state
    vicp_pkg::vicp_state_type state_r, state_nxt;
    logic [15:0] tick_cnt_r, tick_cnt_nxt;
    logic [16:0] acc_r, acc_nxt;
    logic out_r, out_nxt;

    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic tick;
    logic [16:0] sum;
    logic [16:0] top_bit;
    logic [15:0] scaled;

    // narrow code to its msbs by clearing the low prec bits, left in place so the carry sits at bit 16
    function automatic logic [15:0] vicp_scale(input logic [15:0] code, input logic [2:0] prec);
        logic [15:0] mask;
        mask = 16'hFFFF << prec;
        vicp_scale = code & mask;
    endfunction

    // full address compare: the upper bits must be zero for a hit
    function automatic logic vicp_hit(input logic [31:0] a, input logic [3:0] ofs);
        vicp_hit = (a[31:4] == 28'h0000000) && (a[3:0] == ofs);
    endfunction

    // ==========================================================
    // apb decode: zero wait states
    // refused writes stay silent; only an unmapped address raises pslverr
    assign pready = 1'b1;
    assign addr_ok = vicp_hit(paddr, vicp_pkg::CTRL_OFS) || vicp_hit(paddr, vicp_pkg::INPUT_OFS)
        || vicp_hit(paddr, vicp_pkg::DIV_OFS);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !penable && !pwrite;
    assign prdata = prdata_r;

    always_comb
    begin
        run_nxt = run_r;
        prec_nxt = prec_r;
        code_nxt = code_r;
        div_nxt = div_r;
        prdata_nxt = prdata_r;
        if (wr_en && vicp_hit(paddr, vicp_pkg::CTRL_OFS))
        begin
            run_nxt = pwdata[vicp_pkg::RUN_BIT];
            if (!run_r)
            begin
                prec_nxt = pwdata[vicp_pkg::PREC_MSB:vicp_pkg::PREC_LSB];
            end
        end
        if (wr_en && vicp_hit(paddr, vicp_pkg::INPUT_OFS) && run_r)
        begin
            code_nxt = pwdata[15:0];
        end
        if (wr_en && vicp_hit(paddr, vicp_pkg::DIV_OFS) && !run_r)
        begin
            div_nxt = (pwdata[15:0] == vicp_pkg::DIV_ZERO) ? vicp_pkg::DIV_RST : pwdata[15:0];
        end
        if (rd_en)
        begin
            // read data captured in setup so it stands through access phase
            if (vicp_hit(paddr, vicp_pkg::CTRL_OFS))
            begin
                prdata_nxt = {28'h0000000, prec_r, run_r};
            end
            else if (vicp_hit(paddr, vicp_pkg::INPUT_OFS))
            begin
                prdata_nxt = {16'h0000, code_r};
            end
            else if (vicp_hit(paddr, vicp_pkg::DIV_OFS))
            begin
                prdata_nxt = {16'h0000, div_r};
            end
            else
            begin
                prdata_nxt = 32'h00000000;
            end
        end
    end

    // clk_en low freezes the registers and the captured read data alike
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_r <= 1'b0;
            prec_r <= vicp_pkg::PREC_RST;
            code_r <= vicp_pkg::CODE_RST;
            div_r <= vicp_pkg::DIV_RST;
            prdata_r <= 32'h00000000;
        end
        else if (clk_en)
        begin
            run_r <= run_nxt;
            prec_r <= prec_nxt;
            code_r <= code_nxt;
            div_r <= div_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // ==========================================================
    // interpolation modulator
    // the counter runs from zero to div minus one, so div clocks per tick
    // a written zero never reaches the counter, it is stored as one
    assign tick = (tick_cnt_r >= div_r - 16'h0001);
    assign scaled = vicp_scale(code_r, prec_r);
    assign sum = acc_r + {1'b0, scaled};
    assign top_bit = 17'h10000;

    always_comb
    begin
        state_nxt = state_r;
        tick_cnt_nxt = tick_cnt_r;
        acc_nxt = acc_r;
        out_nxt = out_r;
        case (state_r)
            vicp_pkg::VICP_IDLE:
            begin
                // the input code survives a stop, so a restart reuses the last code
                tick_cnt_nxt = 16'h0000;
                acc_nxt = 17'h00000;
                out_nxt = 1'b0;
                if (run_r)
                begin
                    state_nxt = vicp_pkg::VICP_RUN;
                end
            end
            vicp_pkg::VICP_RUN:
            begin
                // a stop wins over a pending tick
                if (!run_r)
                begin
                    state_nxt = vicp_pkg::VICP_IDLE;
                    tick_cnt_nxt = 16'h0000;
                    acc_nxt = 17'h00000;
                    out_nxt = 1'b0;
                end
                else if (tick)
                begin
                    tick_cnt_nxt = 16'h0000;
                    // carry out of the 16-bit accumulator is the density bit
                    out_nxt = sum[16];
                    acc_nxt = sum & (top_bit - 17'h00001);
                end
                else
                begin
                    tick_cnt_nxt = tick_cnt_r + 16'h0001;
                end
            end
            default:
            begin
                state_nxt = vicp_pkg::VICP_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= vicp_pkg::VICP_IDLE;
            tick_cnt_r <= 16'h0000;
            acc_r <= 17'h00000;
            out_r <= 1'b0;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            acc_r <= acc_nxt;
            out_r <= out_nxt;
        end
    end

    // output comes straight from a flop, so the pin never glitches between ticks
    assign vcxo_ctrl_out = out_r;

endmodule

// File: verification/vicp_assertions.sv
module vicp_checker
(
    // clock and reset
    input logic pclk,
    input logic presetn,
    input logic clk_en,
    // apb
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [31:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // oscillator
    input logic vcxo_ctrl_out
);
    // ==========================================================
    // decode
    wire rs = psel && !penable && !pwrite && clk_en;
    wire acc = psel && penable;
    wire hit = paddr == 32'h0 || paddr == 32'h4 || paddr == 32'h8;
    wire stop = acc && pwrite && clk_en && paddr == 32'h0 && !pwdata[0];
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========================================================
    // checks
    AST_READY: assert property (psel |-> pready) else $error("no ready");
    AST_UNMAP: assert property (acc && !hit |-> pslverr) else $error("no error");
    AST_MAP: assert property (acc && hit |-> !pslverr) else $error("bad error");
    AST_UNMAP_RD: assert property (rs && !hit |=> prdata == 32'h0) else $error("rd");
    AST_HOLD: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("hold");
    AST_CTRL_RSV: assert property (rs && paddr == 32'h0 |=> prdata[31:4] == 28'h0)
        else $error("ctrl");
    AST_CODE_RSV: assert property (rs && paddr == 32'h4 |=> prdata[31:16] == 16'h0)
        else $error("code");
    AST_DIV_RD: assert property (rs && paddr == 32'h8 |=> prdata[31:16] == 16'h0 && prdata[15:0] != 16'h0)
        else $error("div");
    // three cycles is the shortest gap before a new write can restart
    AST_IDLE_LOW: assert property (stop |=> ##1 (!vcxo_ctrl_out)[*3]) else $error("out");
    AST_COV_STOP: cover property (stop);
    AST_COV_UNMAP: cover property (acc && !hit);
    AST_COV_PULSE: cover property ($rose(vcxo_ctrl_out));
endmodule
bind vicp_top vicp_checker u_chk (.*);

// File: verification/vicp_vcxo_model.sv
module vicp_vcxo_model
(
    // clock and reset
    input logic pclk,
    input logic presetn,
    // control line and pulse count
    input logic ctrl_in,
    input logic clr,
    output logic [15:0] pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last;
    // rising edges, not high cycles, so the count is divider independent
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn || clr)
            pulses <= 16'h0;
        else if (ctrl_in && !last)
            pulses <= pulses + 16'h1;
        last <= ctrl_in;
    end
endmodule

// File: verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
        $display("ERROR %0t got %h exp %h", $time, a, e); end end
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, vcxo_ctrl_out, clr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [15:0] pulses;
    int err_count, tests_run;
    vicp_top uut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .vcxo_ctrl_out);
    vicp_vcxo_model vcxo (.pclk, .presetn, .ctrl_in(vcxo_ctrl_out), .clr, .pulses);
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ==========================================================
    // apb master
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    // count output pulses over a whole number of modulator periods
    task automatic window(input int n, input logic [15:0] e);
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (n) @(posedge pclk);
        #1;
        `CHK(pulses, e)
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #200us;
        err_count++;
        report_and_stop();
    end
    // ==========================================================
    // tests
    initial
    begin
        {psel, penable, pwrite, clr, presetn} = 5'h0;
        clk_en = 1'b1;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'h0, 32'h0);
        chk(32'h8, 32'h1);
        chk(32'hC, 32'h0);
        `CHK(err, 1'b1)
        wr(32'h4, 32'h1234);
        chk(32'h4, 32'h0);
        wr(32'h0, 32'hFFFF_FFF8);
        chk(32'h0, 32'h8);
        $display("test registers done");
        wr(32'h0, 32'h0);
        wr(32'h8, 32'h0);
        chk(32'h8, 32'h1);
        wr(32'h0, 32'h1);
        wr(32'h4, 32'h4000);
        chk(32'h4, 32'h4000);
        window(64, 16'h10);
        wr(32'h0, 32'hF);
        wr(32'h8, 32'h5);
        chk(32'h8, 32'h1);
        chk(32'h0, 32'h1);
        window(64, 16'h10);
        // clock enable low freezes the modulator, so no edge may appear
        @(posedge pclk);
        clk_en <= 1'b0;
        window(64, 16'h0);
        @(posedge pclk);
        clk_en <= 1'b1;
        wr(32'h0, 32'hE);
        chk(32'h0, 32'h0);
        $display("test run done");
        wr(32'h0, 32'hE);
        wr(32'h8, 32'h2);
        chk(32'h8, 32'h2);
        wr(32'h0, 32'hF);
        wr(32'h4, 32'h407F);
        window(128, 16'h10);
        wr(32'h4, 32'h007F);
        window(1200, 16'h0);
        $display("test precision done");
        report_and_stop();
    end
endmodule
